// ### pkg/lrs_pkg.sv
// shared constants, register map and carriers of the display memory and line scan block
package lrs_pkg;
   localparam int unsigned COLS       = 160;
   localparam int unsigned GRAY_PAGES = 33;
   localparam int unsigned MEM_AW     = 13;
   localparam logic [7:0]  COL_LAST   = 8'h9f;
   localparam logic [7:0]  PAGE_LAST  = 8'h32;
   localparam logic [7:0]  LINE_LAST  = 8'h83;
   localparam logic [2:0]  FRM_LAST   = 3'h6;
   localparam logic [2:0]  GRAY_LEVEL_MAX = 3'h5;

   localparam logic [7:0]  OFS_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_ADDR   = 8'h04;
   localparam logic [7:0]  OFS_XFER   = 8'h08;
   localparam logic [7:0]  OFS_SCROLL = 8'h0c;
   localparam logic [7:0]  OFS_START  = 8'h10;
   localparam logic [7:0]  OFS_GRAY   = 8'h14;
   localparam logic [7:0]  OFS_STATUS = 8'h18;

   localparam int unsigned XFER_DCS_BIT = 8;
   localparam logic [7:0]  RST_DUTY   = 8'h84;
   localparam logic [5:0]  RST_GRAY   = 6'h19;

   typedef enum logic [1:0] {
      SCR_FULL,
      SCR_UPPER,
      SCR_LOWER,
      SCR_CENTER
   } lrs_scroll_mode_t;

   typedef struct packed {
      logic serial_if;
      logic page_dir;
      logic com_reverse;
      logic seg_reverse;
      logic gray_mode;
      logic all_on;
      logic invert;
      logic disp_on;
   } lrs_ctrl_t;

   typedef struct packed {
      lrs_scroll_mode_t mode;
      logic [7:0]       count;
      logic [7:0]       bottom;
      logic [7:0]       top;
   } lrs_scroll_t;

   typedef struct packed {
      logic [2:0] level2;
      logic [2:0] level1;
   } lrs_gray_t;

   typedef struct packed {
      logic       disp_on;
      logic       all_on;
      logic       invert;
      logic       gray_mode;
      logic [2:0] frm_phase;
      lrs_gray_t  gray;
   } lrs_pix_cfg_t;
endpackage

// ### src/lrs_pixel.sv
// one segment's pixel decode: gray or binary code, modulation and output latch modifiers
`timescale 1ns/1ps
module lrs_pixel (
   input  wire logic [1:0]           code_i, // stored pixel code
   input  wire lrs_pkg::lrs_pix_cfg_t cfg_i, // display settings and modulation phase
   output logic                      on_o    // segment selected
);
   logic [2:0] level;
   logic       raw;

   always_comb begin
      level = (code_i == 2'h2) ? cfg_i.gray.level2 : cfg_i.gray.level1;
      if (level > lrs_pkg::GRAY_LEVEL_MAX) begin
         level = lrs_pkg::GRAY_LEVEL_MAX;
      end
      if (!cfg_i.gray_mode) begin
         raw = code_i[0];
      end else if (code_i == 2'h3 || code_i == 2'h0) begin
         raw = code_i[1];
      end else begin
         raw = (cfg_i.frm_phase <= level);
      end
      // modifiers act on the latch value only, memory is untouched
      on_o = cfg_i.disp_on & (cfg_i.all_on | (raw ^ cfg_i.invert));
   end
endmodule

// ### src/lrs_line_scan.sv
// scan line address sequencer with full, upper, lower and center area scroll
`timescale 1ns/1ps
module lrs_line_scan (
   input  wire logic                 clock_i,      // system clock
   input  wire logic                 resetn_i,     // synchronous reset, active low
   input  wire logic                 step_i,       // one line period elapsed
   input  wire lrs_pkg::lrs_scroll_t scroll_i,     // area scroll setting
   input  wire logic [7:0]           start_line_i, // scroll start line
   input  wire logic [7:0]           duty_i,       // lines per frame
   output logic      [7:0]           line_o,       // memory line now scanned
   output logic      [7:0]           row_o,        // display row now scanned
   output logic                      frame_o       // pulse: frame restarts
);
   typedef enum logic [1:0] {
      PH_TOP,
      PH_SCROLL,
      PH_BOTTOM
   } lrs_phase_t;

   typedef struct packed {
      lrs_phase_t phase;
      logic [7:0] line;
      logic [7:0] row;
      logic [7:0] cnt;
   } lrs_scan_state_t;

   lrs_scan_state_t s_q;
   lrs_scan_state_t s_d;

   function automatic lrs_scan_state_t restart(input lrs_pkg::lrs_scroll_t sc,
                                                input logic [7:0] start);
      lrs_scan_state_t r;
      r = '0;
      r.phase = PH_SCROLL;
      r.line  = start;
      if ((sc.mode == lrs_pkg::SCR_LOWER || sc.mode == lrs_pkg::SCR_CENTER)
          && sc.top != 8'h00) begin
         r.phase = PH_TOP;
         r.line  = 8'h00;
      end
      return r;
   endfunction

   always_comb begin
      logic [7:0] cnt_n;
      cnt_n   = 8'(s_q.cnt + 8'h01);
      s_d     = s_q;
      frame_o = 1'b0;
      if (step_i) begin
         s_d.row = 8'(s_q.row + 8'h01);
         unique case (s_q.phase)
            PH_TOP: begin
               if (s_q.line == 8'(scroll_i.top - 8'h01)) begin
                  s_d.phase = PH_SCROLL;
                  s_d.line  = start_line_i;
                  s_d.cnt   = 8'h00;
               end else begin
                  s_d.line = 8'(s_q.line + 8'h01);
               end
            end
            PH_SCROLL: begin
               s_d.cnt = cnt_n;
               if (scroll_i.mode == lrs_pkg::SCR_FULL) begin
                  s_d.line = (s_q.line >= lrs_pkg::LINE_LAST) ? 8'h00
                                                            : 8'(s_q.line + 8'h01);
               end else if (cnt_n == scroll_i.count) begin
                  s_d.phase = PH_BOTTOM;
                  s_d.line  = 8'(scroll_i.bottom + 8'h01);
                  if (scroll_i.mode == lrs_pkg::SCR_LOWER) begin
                     frame_o = 1'b1;
                  end
               end else if (scroll_i.mode == lrs_pkg::SCR_UPPER) begin
                  // a mode or bottom rewritten mid-frame must not run the line past memory
                  s_d.line = 8'(s_q.line + 8'h01);
                  if (s_q.line == scroll_i.bottom || s_q.line >= lrs_pkg::LINE_LAST) begin
                     s_d.line = 8'h00;
                  end
               end else begin
                  s_d.line = (s_q.line >= lrs_pkg::LINE_LAST) ? scroll_i.top
                                                            : 8'(s_q.line + 8'h01);
               end
            end
            PH_BOTTOM: begin
               if (s_q.line >= lrs_pkg::LINE_LAST) begin
                  frame_o = 1'b1;
               end else begin
                  s_d.line = 8'(s_q.line + 8'h01);
               end
            end
            default: begin
               frame_o = 1'b1;
            end
         endcase
         // duty bounds the frame whatever the scroll sequence still has left
         if (s_q.row == 8'(duty_i - 8'h01)) begin
            frame_o = 1'b1;
         end
         if (frame_o) begin
            s_d = restart(scroll_i, start_line_i);
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign line_o = s_q.line;
   assign row_o  = s_q.row;
endmodule

// ### src/lrs_top.sv
// display memory, host access pipeline, scan fetch and apb register slave
`timescale 1ns/1ps
module lrs_top #(
   parameter int unsigned LINE_DIV = 64,                  // clocks per scanned line
   parameter int unsigned PAGES    = lrs_pkg::GRAY_PAGES  // stored pages
) (
   input  wire logic        clock_i,       // 20 MHz system clock
   input  wire logic        resetn_i,      // synchronous reset, active low
   input  wire logic        psel_i,        // apb select
   input  wire logic        penable_i,     // apb access phase
   input  wire logic        pwrite_i,      // apb write
   input  wire logic [7:0]  paddr_i,       // apb byte address
   input  wire logic [31:0] pwdata_i,      // apb write data
   input  wire logic [3:0]  pstrb_i,       // apb byte enables
   output logic      [31:0] prdata_o,      // apb read data
   output logic             pready_o,      // apb ready
   output logic             pslverr_o,     // apb error, unmapped address
   output logic [lrs_pkg::COLS-1:0] seg_on_o, // latched segment states
   output logic      [7:0]  com_index_o,   // common output being driven
   output logic      [7:0]  line_addr_o,   // memory line on the latch
   output logic             frame_o        // pulse: new frame begins
);
   typedef struct packed {
      lrs_pkg::lrs_ctrl_t   ctrl;
      logic [7:0]           page;
      logic [7:0]           col;
      logic [7:0]           holder;
      logic                 pend;
      logic [lrs_pkg::MEM_AW-1:0] wr_idx;
      lrs_pkg::lrs_scroll_t scroll;
      logic [7:0]           start;
      logic [7:0]           duty;
      lrs_pkg::lrs_gray_t   gray;
      logic [7:0]           last_cmd;
      logic [15:0]          div;
      logic [2:0]           frame_rate_modulation;
      logic [lrs_pkg::COLS-1:0] seg;
      logic [7:0]           com;
      logic [7:0]           line;
      logic                 fs;
   } lrs_top_state_t;

   lrs_top_state_t st_q;
   lrs_top_state_t st_d;

   // flip-flop store; the scan side reads it on its own port, host traffic never blocks it
   logic [7:0] mem_q [PAGES*lrs_pkg::COLS];

   logic                      acc;
   logic                      hit;
   logic [31:0]               rdata;
   logic                      tick;
   logic                      scan_frame;
   logic [7:0]                scan_line;
   logic [7:0]                scan_row;
   logic [7:0]                fetch_page;
   logic [2:0]                fetch_bit;
   logic [lrs_pkg::COLS-1:0]  seg_w;
   lrs_pkg::lrs_pix_cfg_t     pix_cfg;

   function automatic logic [lrs_pkg::MEM_AW-1:0] mem_index(input logic [7:0] pg,
                                                            input logic [7:0] cl);
      return lrs_pkg::MEM_AW'(pg * lrs_pkg::COLS + cl);
   endfunction

   function automatic logic [15:0] next_addr(input logic       page_dir,
                                             input logic [7:0] pg,
                                             input logic [7:0] cl);
      logic [7:0] p;
      logic [7:0] c;
      p = pg;
      c = cl;
      if (pg == lrs_pkg::PAGE_LAST && cl == lrs_pkg::COL_LAST) begin
         p = 8'h00;
         c = 8'h00;
      end else if (page_dir) begin
         if (pg >= lrs_pkg::PAGE_LAST) begin
            p = 8'h00;
            c = 8'(cl + 8'h01);
         end else begin
            p = 8'(pg + 8'h01);
         end
      end else begin
         if (cl >= lrs_pkg::COL_LAST) begin
            c = 8'h00;
            p = 8'(pg + 8'h01);
         end else begin
            c = 8'(cl + 8'h01);
         end
      end
      return {p, c};
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   assign acc      = psel_i & penable_i;
   assign pready_o = 1'b1;

   // register read view, also the old value for byte-lane merging
   always_comb begin
      rdata = '0;
      hit   = 1'b1;
      unique case (paddr_i)
         lrs_pkg::OFS_CTRL:   rdata = 32'(st_q.ctrl);
         lrs_pkg::OFS_ADDR:   rdata = 32'({st_q.page, st_q.col});
         lrs_pkg::OFS_XFER: begin
            if (!st_q.ctrl.serial_if) begin
               rdata = 32'(st_q.holder);
            end
         end
         lrs_pkg::OFS_SCROLL: rdata = 32'(st_q.scroll);
         lrs_pkg::OFS_START:  rdata = 32'({st_q.duty, st_q.start});
         lrs_pkg::OFS_GRAY:   rdata = 32'(st_q.gray);
         lrs_pkg::OFS_STATUS: rdata = 32'({st_q.pend, st_q.com, st_q.line, st_q.last_cmd});
         default:             hit   = 1'b0;
      endcase
   end

   assign prdata_o  = (psel_i && !pwrite_i) ? rdata : '0;
   assign pslverr_o = acc & ~hit;

   assign tick = (st_q.div == 16'(LINE_DIV - 1));

   always_comb begin
      logic [31:0] wv;
      logic [15:0] na;
      wv = wmerge(rdata, pwdata_i, pstrb_i);
      na = next_addr(st_q.ctrl.page_dir, st_q.page, st_q.col);
      st_d      = st_q;
      st_d.pend = 1'b0;
      st_d.fs   = 1'b0;
      if (acc && hit && pwrite_i) begin
         unique case (paddr_i)
            lrs_pkg::OFS_CTRL: st_d.ctrl = lrs_pkg::lrs_ctrl_t'(wv[7:0]);
            lrs_pkg::OFS_ADDR: begin
               st_d.col  = wv[7:0];
               st_d.page = wv[15:8];
            end
            lrs_pkg::OFS_XFER: begin
               if (pwdata_i[lrs_pkg::XFER_DCS_BIT]) begin
                  st_d.holder = pwdata_i[7:0];
                  st_d.pend   = (st_q.page < PAGES);
                  st_d.wr_idx = mem_index(st_q.page, st_q.col);
                  {st_d.page, st_d.col} = na;
               end else begin
                  st_d.last_cmd = pwdata_i[7:0];
               end
            end
            lrs_pkg::OFS_SCROLL: st_d.scroll = lrs_pkg::lrs_scroll_t'(wv[25:0]);
            lrs_pkg::OFS_START: begin
               st_d.start = wv[7:0];
               st_d.duty  = wv[15:8];
            end
            lrs_pkg::OFS_GRAY:  st_d.gray = lrs_pkg::lrs_gray_t'(wv[5:0]);
            default: begin
            end
         endcase
      end
      // read: old holder went out on prdata, now refill from the current address
      if (acc && hit && !pwrite_i && paddr_i == lrs_pkg::OFS_XFER
          && !st_q.ctrl.serial_if) begin
         st_d.holder = (st_q.page < PAGES) ? mem_q[mem_index(st_q.page, st_q.col)]
                                           : 8'h00;
         {st_d.page, st_d.col} = na;
      end
      // line timing and output latch
      st_d.div = tick ? 16'h0000 : 16'(st_q.div + 16'h0001);
      if (tick) begin
         st_d.seg  = seg_w;
         st_d.line = scan_line;
         st_d.com  = st_q.ctrl.com_reverse ? 8'(lrs_pkg::LINE_LAST - scan_row)
                                           : scan_row;
         st_d.fs   = (scan_row == 8'h00);
      end
      if (scan_frame) begin
         st_d.frame_rate_modulation = (st_q.frame_rate_modulation >= lrs_pkg::FRM_LAST) ? 3'h0 : 3'(st_q.frame_rate_modulation + 3'h1);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         st_q      <= '0;
         st_q.duty <= lrs_pkg::RST_DUTY;
         st_q.gray <= lrs_pkg::lrs_gray_t'(lrs_pkg::RST_GRAY);
      end else begin
         st_q <= st_d;
      end
   end

   // commit one cycle after capture, ahead of any following apb transfer
   always_ff @(posedge clock_i) begin
      if (st_q.pend) begin
         mem_q[st_q.wr_idx] <= st_q.holder;
      end
   end

   lrs_line_scan u_scan (
      .clock_i      (clock_i),
      .resetn_i     (resetn_i),
      .step_i       (tick),
      .scroll_i     (st_q.scroll),
      .start_line_i (st_q.start),
      .duty_i       (st_q.duty),
      .line_o       (scan_line),
      .row_o        (scan_row),
      .frame_o      (scan_frame)
   );

   // gray packs four lines per byte, binary eight
   always_comb begin
      if (st_q.ctrl.gray_mode) begin
         fetch_page = {2'b00, scan_line[7:2]};
         fetch_bit  = {scan_line[1:0], 1'b0};
      end else begin
         fetch_page = {3'b000, scan_line[7:3]};
         fetch_bit  = scan_line[2:0];
      end
   end

   assign pix_cfg = '{disp_on:   st_q.ctrl.disp_on,
                      all_on:    st_q.ctrl.all_on,
                      invert:    st_q.ctrl.invert,
                      gray_mode: st_q.ctrl.gray_mode,
                      frm_phase: st_q.frame_rate_modulation,
                      gray:      st_q.gray};

   for (genvar s = 0; s < lrs_pkg::COLS; s++) begin : g_seg
      logic [7:0] col_w;
      logic [7:0] byte_w;
      logic [1:0] code_w;
      assign col_w  = st_q.ctrl.seg_reverse ? 8'(lrs_pkg::COLS - 1 - s) : 8'(s);
      assign byte_w = (fetch_page < PAGES) ? mem_q[mem_index(fetch_page, col_w)] : 8'h00;
      assign code_w = st_q.ctrl.gray_mode ? byte_w[fetch_bit +: 2]
                                          : {1'b0, byte_w[fetch_bit]};
      lrs_pixel u_pix (
         .code_i (code_w),
         .cfg_i  (pix_cfg),
         .on_o   (seg_w[s])
      );
   end

   assign seg_on_o    = st_q.seg;
   assign com_index_o = st_q.com;
   assign line_addr_o = st_q.line;
   assign frame_o     = st_q.fs;
endmodule

// ### test/lrs_checker.sv
// concurrent checks on the display block's apb port and scan outputs
`timescale 1ns/1ps
module lrs_checker #(
   parameter int unsigned LINE_DIV = 64 // clocks per line, hold check needs 4 or more
) (
   input wire logic        clock_i,     // system clock
   input wire logic        resetn_i,    // synchronous reset, active low
   input wire logic        psel_i,      // apb select
   input wire logic        penable_i,   // apb access phase
   input wire logic        pwrite_i,    // apb write
   input wire logic [7:0]  paddr_i,     // apb byte address
   input wire logic [31:0] prdata_o,    // apb read data
   input wire logic        pready_o,    // apb ready
   input wire logic        pslverr_o,   // apb error
   input wire logic [7:0]  com_index_o, // common output driven
   input wire logic [7:0]  line_addr_o, // memory line on the latch
   input wire logic        frame_o      // frame start pulse
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);

   property p_ready;
      pready_o;
   endproperty
   a_ready: assert property (p_ready) else $error("pready not high");
   property p_err;
      psel_i && penable_i |-> pslverr_o == (paddr_i > 8'h18 || paddr_i[1:0] != 2'b00);
   endproperty
   a_err: assert property (p_err) else $error("pslverr wrong for address");
   property p_rd_idle;
      !(psel_i && !pwrite_i) |-> prdata_o == 32'h0000_0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
   property p_frame_gap;
      frame_o |=> !frame_o [*3];
   endproperty
   a_frame_gap: assert property (p_frame_gap) else $error("frame pulses too close");
   property p_frame_com;
      frame_o |-> com_index_o == 8'h00 || com_index_o == 8'h83;
   endproperty
   a_frame_com: assert property (p_frame_com) else $error("top row not on end common");
   property p_com_range;
      com_index_o <= 8'h83;
   endproperty
   a_com_range: assert property (p_com_range) else $error("common index out of range");
   property p_line_range;
      line_addr_o <= lrs_pkg::LINE_LAST;
   endproperty
   a_line_range: assert property (p_line_range) else $error("line beyond memory");
   property p_line_hold;
      $changed(line_addr_o) |=> $stable(line_addr_o) [*3];
   endproperty
   a_line_hold: assert property (p_line_hold) else $error("line latch moved early");
endmodule

bind lrs_top lrs_checker #(.LINE_DIV(LINE_DIV)) u_chk (
   .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .com_index_o(com_index_o), .line_addr_o(line_addr_o),
   .frame_o(frame_o));

// ### test/lrs_host.sv
// apb host model standing in for the microprocessor side
`timescale 1ns/1ps
module lrs_host (
   input  wire logic        clock_i,          // system clock
   input  wire logic [31:0] prdata_i,         // read data
   input  wire logic        pready_i,         // ready
   input  wire logic        pslverr_i,        // error
   output logic             psel_o = 1'b0,    // select
   output logic             penable_o = 1'b0, // access phase
   output logic             pwrite_o = 1'b0,  // direction
   output logic      [7:0]  paddr_o = 8'h00,  // byte address
   output logic      [31:0] pwdata_o = 32'h0000_0000, // write data
   output logic      [3:0]  pstrb_o = 4'hf    // byte enables, whole words only
);
   // one transfer; a data byte carries the select bit high, a command low
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err, output logic to);
      int n;
      psel_o   <= 1'b1;
      pwrite_o <= w;
      paddr_o  <= a;
      pwdata_o <= d;
      @(posedge clock_i);
      penable_o <= 1'b1;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready_i !== 1'b1 && n < 64);
      rd  = prdata_i;
      err = pslverr_i;
      to  = pready_i !== 1'b1;
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
      // released bus shows no stale request
      paddr_o   <= ~a;
      pwdata_o  <= ~d;
      @(posedge clock_i);
   endtask
endmodule

// ### test/lrs_top_tb.sv
// self-checking bench: register map, memory pipeline, addressing, pixels, scroll
`timescale 1ns/1ps
module lrs_top_tb;
   logic                      clock_i;
   logic                      resetn_i;
   logic                      psel, penable, pwrite, pready, pslverr, frame;
   logic [7:0]                paddr;
   logic [31:0]               pwdata, prdata, r;
   logic [3:0]                pstrb;
   logic [lrs_pkg::COLS-1:0]  seg_on;
   logic [7:0]                com_index, line_addr;
   logic                      e, t;
   int                        errors, checks_done, i, j;
   logic [15:0] wctl [4] = '{16'h0000, 16'h0000, 16'h0040, 16'h0040};
   logic [15:0] wat  [4] = '{16'h029f, 16'h329f, 16'h3204, 16'h329f};
   logic [15:0] wexp [4] = '{16'h0300, 16'h0000, 16'h0005, 16'h0000};
   // ctrl, line, seg 159 flag, expected state; stored byte is e4
   logic [15:0] ptab [10] = '{16'h0900, 16'h0931, 16'h0b01, 16'h0b30, 16'h1933,
                              16'h0121, 16'h0110, 16'h0501, 16'h0830, 16'h2900};
   logic [31:0] stab [4] = '{32'h0000_0000, 32'h0103_0500, 32'h0203_0003, 32'h0303_0a02};
   logic [7:0]  dl   [4] = '{8'h04, 8'h04, 8'h82, 8'h04};
   logic [47:0] seq  [4] = '{48'h0405_0607_0809, 48'h0405_0006_0708,
                             48'h0001_0282_8303, 48'h0001_0405_060b};

   lrs_top #(.LINE_DIV(4)) dut (
      .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .seg_on_o(seg_on),
      .com_index_o(com_index), .line_addr_o(line_addr), .frame_o(frame));
   lrs_host host (
      .clock_i(clock_i), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
      .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
      .pwdata_o(pwdata), .pstrb_o(pstrb));

   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      checks_done++;
      if (g !== x) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      host.xfer(w, a, d, r, e, t);
      if (t) begin
         chk("pready wait", 32'h0000_0001, 32'h0000_0000);
         report_and_stop();
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string nm);
      acc(1'b0, a, 32'h0000_0000);
      chk(nm, x, r);
   endtask
   task automatic wait_frame();
      int n;
      @(posedge clock_i);
      for (n = 0; n < 1000 && frame !== 1'b1; n++) @(posedge clock_i);
      if (n == 1000) begin
         chk("frame wait", 32'h0000_0001, 32'h0000_0000);
         report_and_stop();
      end
   endtask
   task automatic pix(input logic [15:0] p);
      int n;
      logic [7:0] c;
      acc(1'b1, lrs_pkg::OFS_CTRL, {24'h00_0000, p[15:8]});
      repeat (5) @(posedge clock_i);
      for (n = 0; n < 700 && line_addr !== {4'h0, p[7:4]}; n++) @(posedge clock_i);
      if (n == 700) begin
         chk("line wait", 32'h0000_0001, 32'h0000_0000);
         report_and_stop();
      end
      chk("segment", {31'h0, p[0]}, {31'h0, seg_on[p[1] ? 159 : 0]});
      // full scroll from line 0: row equals line, reversed commons count down
      c = p[13] ? 8'(lrs_pkg::LINE_LAST - {4'h0, p[7:4]}) : {4'h0, p[7:4]};
      chk("common", {24'h00_0000, c}, {24'h00_0000, com_index});
   endtask

   initial begin
      errors = 0;
      checks_done = 0;
      resetn_i = 1'b0;
      repeat (6) @(posedge clock_i);
      resetn_i <= 1'b1;
      @(posedge clock_i);
      rdc(lrs_pkg::OFS_GRAY, 32'h0000_0019, "gray reset");
      rdc(lrs_pkg::OFS_START, 32'h0000_8400, "duty reset");
      host.xfer(1'b0, 8'h1c, 32'h0000_0000, r, e, t);
      chk("unmapped error", 32'h0000_0001, {31'h0, e});
      $display("test reset and map done");
      acc(1'b1, lrs_pkg::OFS_ADDR, 32'h0000_0005);
      acc(1'b1, lrs_pkg::OFS_XFER, 32'h0000_01a5);
      acc(1'b1, lrs_pkg::OFS_XFER, 32'h0000_013c);
      rdc(lrs_pkg::OFS_ADDR, 32'h0000_0007, "addr after writes");
      acc(1'b1, lrs_pkg::OFS_ADDR, 32'h0000_0005);
      acc(1'b0, lrs_pkg::OFS_XFER, 32'h0000_0000);
      rdc(lrs_pkg::OFS_XFER, 32'h0000_00a5, "first data");
      rdc(lrs_pkg::OFS_XFER, 32'h0000_003c, "second data");
      rdc(lrs_pkg::OFS_ADDR, 32'h0000_0008, "addr after reads");
      acc(1'b1, lrs_pkg::OFS_XFER, 32'h0000_005a);
      rdc(lrs_pkg::OFS_ADDR, 32'h0000_0008, "addr after command");
      acc(1'b0, lrs_pkg::OFS_STATUS, 32'h0000_0000);
      chk("command byte", 32'h0000_005a, {24'h00_0000, r[7:0]});
      acc(1'b1, lrs_pkg::OFS_CTRL, 32'h0000_0080);
      rdc(lrs_pkg::OFS_XFER, 32'h0000_0000, "serial read");
      rdc(lrs_pkg::OFS_ADDR, 32'h0000_0008, "serial addr");
      $display("test pipeline done");
      for (i = 0; i < 4; i++) begin
         acc(1'b1, lrs_pkg::OFS_CTRL, {16'h0000, wctl[i]});
         acc(1'b1, lrs_pkg::OFS_ADDR, {16'h0000, wat[i]});
         acc(1'b1, lrs_pkg::OFS_XFER, 32'h0000_0100);
         rdc(lrs_pkg::OFS_ADDR, {16'h0000, wexp[i]}, "wrap addr");
      end
      $display("test address wrap done");
      acc(1'b1, lrs_pkg::OFS_CTRL, 32'h0000_0000);
      acc(1'b1, lrs_pkg::OFS_ADDR, 32'h0000_0000);
      acc(1'b1, lrs_pkg::OFS_XFER, 32'h0000_01e4);
      for (i = 0; i < 10; i++) pix(ptab[i]);
      // code 01 at level 2 is lit in three of any seven consecutive frames
      acc(1'b1, lrs_pkg::OFS_CTRL, 32'h0000_0009);
      acc(1'b1, lrs_pkg::OFS_GRAY, 32'h0000_0002);
      j = 0;
      wait_frame();
      for (i = 0; i < 7; i++) begin
         wait_frame();
         repeat (4) @(posedge clock_i);
         if (seg_on[0] === 1'b1) j++;
      end
      chk("halftone frames", 32'h0000_0003, j);
      acc(1'b1, lrs_pkg::OFS_ADDR, 32'h0000_0000);
      acc(1'b0, lrs_pkg::OFS_XFER, 32'h0000_0000);
      rdc(lrs_pkg::OFS_XFER, 32'h0000_00e4, "memory kept");
      $display("test pixels done");
      for (i = 0; i < 4; i++) begin
         acc(1'b1, lrs_pkg::OFS_SCROLL, stab[i]);
         acc(1'b1, lrs_pkg::OFS_START, {16'h0000, 8'h84, dl[i]});
         wait_frame();
         wait_frame();
         for (j = 0; j < 6; j++) begin
            chk("scan line", {24'h00_0000, seq[i][47-8*j -: 8]}, {24'h00_0000, line_addr});
            repeat (4) @(posedge clock_i);
         end
      end
      $display("test scroll done");
      report_and_stop();
   end
endmodule
